// *** src/right_agc_pkg.sv ***
package right_agc_pkg;

	// Register offsets on the device's control bus.
	localparam logic [7:0] ADDR_ATTACK = 8'h69;
	localparam logic [7:0] ADDR_DECAY  = 8'h6A;

	// Reset value of both registers.
	localparam logic [7:0] REG_RESET = 8'h00;

	// Field layout, shared by both registers.
	localparam int SEL_BIT  = 7;
	localparam int BASE_MSB = 6;
	localparam int BASE_LSB = 5;
	localparam int MULT_MSB = 4;
	localparam int MULT_LSB = 2;

	// Width of every time value in milliseconds; 350 ms times 128 needs sixteen bits.
	localparam int TIME_W = 16;

	// Baseline attack times in ms: 7, 8, 10 and 11.
	localparam logic [15:0] ATTACK_BASE_0 = 16'h0007;
	localparam logic [15:0] ATTACK_BASE_1 = 16'h0008;
	localparam logic [15:0] ATTACK_BASE_2 = 16'h000A;
	localparam logic [15:0] ATTACK_BASE_3 = 16'h000B;

	// Baseline decay times in ms: 50, 150, 250 and 350.
	localparam logic [15:0] DECAY_BASE_0 = 16'h0032;
	localparam logic [15:0] DECAY_BASE_1 = 16'h0096;
	localparam logic [15:0] DECAY_BASE_2 = 16'h00FA;
	localparam logic [15:0] DECAY_BASE_3 = 16'h015E;

	// Codec rate divisor codes, in half steps (divisor times two).
	localparam logic [3:0] DIV_1_0 = 4'h2;
	localparam logic [3:0] DIV_1_5 = 4'h3;
	localparam logic [3:0] DIV_2_0 = 4'h4;
	localparam logic [3:0] DIV_2_5 = 4'h5;
	localparam logic [3:0] DIV_3_0 = 4'h6;
	localparam logic [3:0] DIV_3_5 = 4'h7;
	localparam logic [3:0] DIV_4_0 = 4'h8;
	localparam logic [3:0] DIV_4_5 = 4'h9;
	localparam logic [3:0] DIV_5_0 = 4'hA;
	localparam logic [3:0] DIV_5_5 = 4'hB;
	localparam logic [3:0] DIV_6_0 = 4'hC;

	// Decay ceilings in ms: 4000, 5600, 8000, 9600, 11200, 16000, 19200, 22400.
	localparam logic [15:0] CEIL_4000  = 16'h0FA0;
	localparam logic [15:0] CEIL_5600  = 16'h15E0;
	localparam logic [15:0] CEIL_8000  = 16'h1F40;
	localparam logic [15:0] CEIL_9600  = 16'h2580;
	localparam logic [15:0] CEIL_11200 = 16'h2BC0;
	localparam logic [15:0] CEIL_16000 = 16'h3E80;
	localparam logic [15:0] CEIL_19200 = 16'h4B00;
	localparam logic [15:0] CEIL_22400 = 16'h5780;

	// Largest multiplier code, a factor of 128.
	localparam logic [2:0] MULT_MAX = 3'h7;

endpackage

// *** src/agc_time_calc.sv ***
`timescale 1ns/1ps

// Effective AGC time for one channel and direction: source select, scaling, ceiling.
module agc_time_calc #(
	parameter int TIME_W = right_agc_pkg::TIME_W
) (
	input  wire logic              use_new,
	input  wire logic [TIME_W-1:0] baseline_ms,
	input  wire logic [2:0]        mult_code,
	input  wire logic [TIME_W-1:0] legacy_ms,
	input  wire logic              apply_ceiling,
	input  wire logic [TIME_W-1:0] ceiling_ms,
	output logic      [TIME_W-1:0] time_ms
);

	// Seven spare bits keep the largest shift from wrapping before the clamp.
	logic [TIME_W+6:0] scaled;
	logic [TIME_W+6:0] raw;

	// Scale the baseline by two to the multiplier code, pick the source, then clamp.
	always_comb begin
		scaled = {7'h00, baseline_ms} << mult_code;
		raw    = use_new ? scaled : {7'h00, legacy_ms};
		if (apply_ceiling && (raw > {7'h00, ceiling_ms})) begin
			time_ms = ceiling_ms;
		end else begin
			time_ms = raw[TIME_W-1:0];
		end
	end

endmodule

// *** src/right_agc_time_control.sv ***
`timescale 1ns/1ps

// What this block does
// - Attack select bit 7: 0 uses legacy attack time, 1 uses this register.
// - Attack baseline bits 6..5 give 7, 8, 10 or 11 ms.
// - Attack multiplier bits 4..2 scale the baseline by 1 up to 128.
// - Decay select bit 7: 0 uses legacy decay time, 1 uses this register.
// - Decay baseline bits 6..5 give 50, 150, 250 or 350 ms.
// - Decay multiplier bits 4..2 scale the baseline by 1 up to 128.
// - Decay ceiling is 4, 5.6, 8, 9.6 s at divisor 1, 1.5, 2, 2.5.
// - Ceiling is 11.2, 16, 19.2, 22.4 s for divisors 3 up to 6.
module right_agc_time_control #(
	parameter int TIME_W = right_agc_pkg::TIME_W
) (
	input  wire logic              clk,
	input  wire logic              rst_n,
	input  wire logic              reg_wr,
	input  wire logic              reg_rd,
	input  wire logic [7:0]        reg_addr,
	input  wire logic [7:0]        reg_wdata,
	output logic      [7:0]        reg_rdata,
	input  wire logic [3:0]        codec_rate_divisor,
	input  wire logic [TIME_W-1:0] legacy_attack_ms,
	input  wire logic [TIME_W-1:0] legacy_decay_ms,
	output logic                   attack_sel_new,
	output logic                   decay_sel_new,
	output logic      [TIME_W-1:0] attack_time_ms,
	output logic      [TIME_W-1:0] decay_time_ms
);

	// The products and ceilings need sixteen bits; narrower widths would wrap.
	if (TIME_W < right_agc_pkg::TIME_W) begin : g_width_check
		$error("TIME_W is too narrow for the scaled AGC times");
	end

	typedef struct packed {
		logic [7:0]        attack;
		logic [7:0]        decay;
		logic [7:0]        rdata;
		logic [TIME_W-1:0] attack_ms;
		logic [TIME_W-1:0] decay_ms;
	} state_t;

	state_t            st;
	state_t            next_st;
	logic [TIME_W-1:0] attack_base;
	logic [TIME_W-1:0] decay_base;
	logic [TIME_W-1:0] decay_ceiling;
	logic [TIME_W-1:0] attack_calc;
	logic [TIME_W-1:0] decay_calc;

	// Baseline attack time from the two-bit field.
	always_comb begin
		case (st.attack[right_agc_pkg::BASE_MSB:right_agc_pkg::BASE_LSB])
			2'h0:    attack_base = TIME_W'(right_agc_pkg::ATTACK_BASE_0);
			2'h1:    attack_base = TIME_W'(right_agc_pkg::ATTACK_BASE_1);
			2'h2:    attack_base = TIME_W'(right_agc_pkg::ATTACK_BASE_2);
			2'h3:    attack_base = TIME_W'(right_agc_pkg::ATTACK_BASE_3);
			default: attack_base = TIME_W'(right_agc_pkg::ATTACK_BASE_0);
		endcase
	end

	// Baseline decay time from the two-bit field.
	always_comb begin
		case (st.decay[right_agc_pkg::BASE_MSB:right_agc_pkg::BASE_LSB])
			2'h0:    decay_base = TIME_W'(right_agc_pkg::DECAY_BASE_0);
			2'h1:    decay_base = TIME_W'(right_agc_pkg::DECAY_BASE_1);
			2'h2:    decay_base = TIME_W'(right_agc_pkg::DECAY_BASE_2);
			2'h3:    decay_base = TIME_W'(right_agc_pkg::DECAY_BASE_3);
			default: decay_base = TIME_W'(right_agc_pkg::DECAY_BASE_0);
		endcase
	end

	// Decay ceiling by divisor; codes outside 1..6 take the nearest documented end.
	always_comb begin
		case (codec_rate_divisor)
			right_agc_pkg::DIV_1_0: decay_ceiling = TIME_W'(right_agc_pkg::CEIL_4000);
			right_agc_pkg::DIV_1_5: decay_ceiling = TIME_W'(right_agc_pkg::CEIL_5600);
			right_agc_pkg::DIV_2_0: decay_ceiling = TIME_W'(right_agc_pkg::CEIL_8000);
			right_agc_pkg::DIV_2_5: decay_ceiling = TIME_W'(right_agc_pkg::CEIL_9600);
			right_agc_pkg::DIV_3_0,
			right_agc_pkg::DIV_3_5: decay_ceiling = TIME_W'(right_agc_pkg::CEIL_11200);
			right_agc_pkg::DIV_4_0,
			right_agc_pkg::DIV_4_5: decay_ceiling = TIME_W'(right_agc_pkg::CEIL_16000);
			right_agc_pkg::DIV_5_0: decay_ceiling = TIME_W'(right_agc_pkg::CEIL_19200);
			right_agc_pkg::DIV_5_5,
			right_agc_pkg::DIV_6_0: decay_ceiling = TIME_W'(right_agc_pkg::CEIL_22400);
			default: begin
				if (codec_rate_divisor < right_agc_pkg::DIV_1_0) begin
					decay_ceiling = TIME_W'(right_agc_pkg::CEIL_4000);
				end else begin
					decay_ceiling = TIME_W'(right_agc_pkg::CEIL_22400);
				end
			end
		endcase
	end

	// Attack path; the ceiling applies only to decay.
	agc_time_calc #(
		.TIME_W(TIME_W)
	) u_attack (
		.use_new       (st.attack[right_agc_pkg::SEL_BIT]),
		.baseline_ms   (attack_base),
		.mult_code     (st.attack[right_agc_pkg::MULT_MSB:right_agc_pkg::MULT_LSB]),
		.legacy_ms     (legacy_attack_ms),
		.apply_ceiling (1'b0),
		.ceiling_ms    (decay_ceiling),
		.time_ms       (attack_calc)
	);

	// Decay path; the ceiling bounds either source.
	agc_time_calc #(
		.TIME_W(TIME_W)
	) u_decay (
		.use_new       (st.decay[right_agc_pkg::SEL_BIT]),
		.baseline_ms   (decay_base),
		.mult_code     (st.decay[right_agc_pkg::MULT_MSB:right_agc_pkg::MULT_LSB]),
		.legacy_ms     (legacy_decay_ms),
		.apply_ceiling (1'b1),
		.ceiling_ms    (decay_ceiling),
		.time_ms       (decay_calc)
	);

	// Register writes, read data and the registered times.
	// Reserved low bits are stored as written so software reads back what it wrote.
	always_comb begin
		next_st           = st;
		next_st.attack_ms = attack_calc;
		next_st.decay_ms  = decay_calc;
		if (reg_wr && (reg_addr == right_agc_pkg::ADDR_ATTACK)) begin
			next_st.attack = reg_wdata;
		end
		if (reg_wr && (reg_addr == right_agc_pkg::ADDR_DECAY)) begin
			next_st.decay = reg_wdata;
		end
		if (reg_rd) begin
			case (reg_addr)
				right_agc_pkg::ADDR_ATTACK: next_st.rdata = st.attack;
				right_agc_pkg::ADDR_DECAY:  next_st.rdata = st.decay;
				default:                    next_st.rdata = right_agc_pkg::REG_RESET;
			endcase
		end
	end

	// Synchronous reset clears every field, so legacy timing is in force at start.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign reg_rdata      = st.rdata;
	assign attack_sel_new = st.attack[right_agc_pkg::SEL_BIT];
	assign decay_sel_new  = st.decay[right_agc_pkg::SEL_BIT];
	assign attack_time_ms = st.attack_ms;
	assign decay_time_ms  = st.decay_ms;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	localparam logic [2:0] MULT_8 = 3'h3;

	// Legacy attack time passes through when the select bit is clear.
	// The reset edge itself loads zero times, so a sampled low reset keeps the check off.
	property p_attack_legacy;
		rst_n && !st.attack[right_agc_pkg::SEL_BIT]
			|=> attack_time_ms == $past(legacy_attack_ms);
	endproperty
	a_attack_legacy: assert property (p_attack_legacy) else $error("legacy attack not used");

	// Smallest attack: baseline 7 ms, factor 1, a written register reaches the output.
	property p_attack_base;
		reg_wr && reg_addr == right_agc_pkg::ADDR_ATTACK && reg_wdata == 8'h80
			|=> ##1 attack_time_ms == TIME_W'(right_agc_pkg::ATTACK_BASE_0);
	endproperty
	a_attack_base: assert property (p_attack_base) else $error("attack baseline wrong");

	// Largest factor on the 7 ms baseline.
	property p_attack_mult;
		st.attack[7:2] == 6'h27 |=>
			attack_time_ms == TIME_W'(right_agc_pkg::ATTACK_BASE_0) << right_agc_pkg::MULT_MAX;
	endproperty
	a_attack_mult: assert property (p_attack_mult) else $error("attack multiplier wrong");

	// Legacy decay passes through when below every ceiling.
	property p_decay_legacy;
		rst_n && !st.decay[right_agc_pkg::SEL_BIT]
			&& legacy_decay_ms < TIME_W'(right_agc_pkg::CEIL_4000)
			|=> decay_time_ms == $past(legacy_decay_ms);
	endproperty
	a_decay_legacy: assert property (p_decay_legacy) else $error("legacy decay not used");

	// Top baseline with factor 1 gives 350 ms.
	property p_decay_base;
		st.decay[7:2] == 6'h38 |=> decay_time_ms == TIME_W'(right_agc_pkg::DECAY_BASE_3);
	endproperty
	a_decay_base: assert property (p_decay_base) else $error("decay baseline wrong");

	// 50 ms times 8 is below every ceiling.
	property p_decay_mult;
		st.decay[7:2] == 6'h23 |=>
			decay_time_ms == TIME_W'(right_agc_pkg::DECAY_BASE_0) << MULT_8;
	endproperty
	a_decay_mult: assert property (p_decay_mult) else $error("decay multiplier wrong");

	// Largest decay setting at divisor 1 clamps to 4 s.
	property p_ceil_low;
		st.decay[7:2] == 6'h3F && codec_rate_divisor == right_agc_pkg::DIV_1_0
			|=> decay_time_ms == TIME_W'(right_agc_pkg::CEIL_4000);
	endproperty
	a_ceil_low: assert property (p_ceil_low) else $error("decay ceiling at divisor 1 wrong");

	// Largest decay setting at divisor 6 clamps to 22.4 s.
	property p_ceil_high;
		st.decay[7:2] == 6'h3F && codec_rate_divisor == right_agc_pkg::DIV_6_0
			|=> decay_time_ms == TIME_W'(right_agc_pkg::CEIL_22400);
	endproperty
	a_ceil_high: assert property (p_ceil_high) else $error("decay ceiling at divisor 6 wrong");

	// Reset leaves both select bits and the read data at zero.
	property p_reset_clear;
		@(posedge clk) disable iff (1'b0)
		!rst_n |=> reg_rdata == 8'h00 && !attack_sel_new && !decay_sel_new;
	endproperty
	a_reset_clear: assert property (p_reset_clear) else $error("reset did not clear");

	// A read of the decay register returns the last value written.
	property p_readback;
		reg_wr && reg_addr == right_agc_pkg::ADDR_DECAY && !reg_rd
			##1 reg_rd && !reg_wr && reg_addr == right_agc_pkg::ADDR_DECAY
			|=> reg_rdata == $past(reg_wdata, 2);
	endproperty
	a_readback: assert property (p_readback) else $error("decay readback wrong");

	c_attack_new: cover property (attack_sel_new && st.attack_ms != legacy_attack_ms);
	c_decay_clamped: cover property (decay_sel_new && decay_time_ms == decay_ceiling);
	c_read_attack: cover property (reg_rd && reg_addr == right_agc_pkg::ADDR_ATTACK ##1 1'b1);

endmodule

// *** verification/tb.sv ***
`timescale 1ns/1ps

module tb;
	logic        clk;
	logic        rst_n;
	logic        reg_wr;
	logic        reg_rd;
	logic [7:0]  reg_addr;
	logic [7:0]  reg_wdata;
	logic [7:0]  reg_rdata;
	logic [3:0]  codec_rate_divisor;
	logic [15:0] legacy_attack_ms;
	logic [15:0] legacy_decay_ms;
	logic        attack_sel_new;
	logic        decay_sel_new;
	logic [15:0] attack_time_ms;
	logic [15:0] decay_time_ms;
	logic [15:0] atk_base [4];
	logic [15:0] dec_base [4];
	logic [15:0] raw;
	int          fail_count;
	int          n_compared;

	right_agc_time_control right_agc_time_control_inst (
		.clk                (clk),
		.rst_n              (rst_n),
		.reg_wr             (reg_wr),
		.reg_rd             (reg_rd),
		.reg_addr           (reg_addr),
		.reg_wdata          (reg_wdata),
		.reg_rdata          (reg_rdata),
		.codec_rate_divisor (codec_rate_divisor),
		.legacy_attack_ms   (legacy_attack_ms),
		.legacy_decay_ms    (legacy_decay_ms),
		.attack_sel_new     (attack_sel_new),
		.decay_sel_new      (decay_sel_new),
		.attack_time_ms     (attack_time_ms),
		.decay_time_ms      (decay_time_ms)
	);

	// The clock runs at 100 MHz.
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// Ceiling per divisor code; codes outside 2..12 follow the nearest end of the table.
	function automatic logic [15:0] ceil_of(input logic [3:0] div);
		case (div)
			4'h0, 4'h1, 4'h2: ceil_of = right_agc_pkg::CEIL_4000;
			4'h3:             ceil_of = right_agc_pkg::CEIL_5600;
			4'h4:             ceil_of = right_agc_pkg::CEIL_8000;
			4'h5:             ceil_of = right_agc_pkg::CEIL_9600;
			4'h6, 4'h7:       ceil_of = right_agc_pkg::CEIL_11200;
			4'h8, 4'h9:       ceil_of = right_agc_pkg::CEIL_16000;
			4'hA:             ceil_of = right_agc_pkg::CEIL_19200;
			default:          ceil_of = right_agc_pkg::CEIL_22400;
		endcase
	endfunction

	// Every comparison is counted; a mismatch is reported at once.
	task automatic chk(input string name, input logic [15:0] expv, input logic [15:0] got);
		n_compared++;
		if (got !== expv) begin
			fail_count++;
			$display("BAD %s expected %h seen %h", name, expv, got);
		end
	endtask

	// One-cycle write strobe, launched just after an edge and taken at the next one.
	task automatic wr(input logic [7:0] addr, input logic [7:0] data);
		@(posedge clk);
		reg_wr    <= 1'b1;
		reg_addr  <= addr;
		reg_wdata <= data;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask

	// Read data is registered, so it is looked at just after the edge that takes the strobe.
	task automatic rd_chk(input logic [7:0] addr, input logic [7:0] expv);
		@(posedge clk);
		reg_rd   <= 1'b1;
		reg_addr <= addr;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		chk("reg_rdata", {8'h00, expv}, {8'h00, reg_rdata});
	endtask

	// Time outputs lag a register write by one edge; waiting two keeps the check settled.
	task automatic settle();
		repeat (2) @(posedge clk);
		#1;
	endtask

	task automatic stop_test();
		$display("Comparisons %0d, mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	// The whole run needs well under a thousand cycles, so this limit only catches a hang.
	initial begin
		#100000;
		fail_count++;
		$display("Watchdog expired");
		stop_test();
	end

	// Main sequence of register accesses and time checks.
	initial begin
		rst_n              = 1'b0;
		reg_wr             = 1'b0;
		reg_rd             = 1'b0;
		reg_addr           = 8'h00;
		reg_wdata          = 8'h00;
		codec_rate_divisor = 4'h2;
		legacy_attack_ms   = 16'h0123;
		legacy_decay_ms    = 16'h0456;
		fail_count         = 0;
		n_compared         = 0;
		atk_base = '{right_agc_pkg::ATTACK_BASE_0, right_agc_pkg::ATTACK_BASE_1,
			right_agc_pkg::ATTACK_BASE_2, right_agc_pkg::ATTACK_BASE_3};
		dec_base = '{right_agc_pkg::DECAY_BASE_0, right_agc_pkg::DECAY_BASE_1,
			right_agc_pkg::DECAY_BASE_2, right_agc_pkg::DECAY_BASE_3};
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		settle();
		rd_chk(right_agc_pkg::ADDR_ATTACK, 8'h00);
		rd_chk(right_agc_pkg::ADDR_DECAY, 8'h00);
		chk("attack_time_ms", legacy_attack_ms, attack_time_ms);
		chk("decay_time_ms", legacy_decay_ms, decay_time_ms);
		chk("attack_sel_new", 16'h0000, {15'h0000, attack_sel_new});
		// Every baseline and multiplier pair, reserved bits kept at zero.
		for (int b = 0; b < 4; b++) begin
			for (int m = 0; m < 8; m++) begin
				wr(right_agc_pkg::ADDR_ATTACK, {1'b1, b[1:0], m[2:0], 2'b00});
				settle();
				chk("attack_time_ms", atk_base[b] << m, attack_time_ms);
			end
		end
		chk("attack_sel_new", 16'h0001, {15'h0000, attack_sel_new});
		rd_chk(right_agc_pkg::ADDR_ATTACK, 8'hFC);
		wr(right_agc_pkg::ADDR_ATTACK, 8'h7C);
		settle();
		chk("attack_time_ms", legacy_attack_ms, attack_time_ms);
		chk("attack_sel_new", 16'h0000, {15'h0000, attack_sel_new});
		// At the top divisor the largest products are clamped to 22.4 s.
		@(posedge clk);
		codec_rate_divisor <= 4'hC;
		for (int b = 0; b < 4; b++) begin
			for (int m = 0; m < 8; m++) begin
				wr(right_agc_pkg::ADDR_DECAY, {1'b1, b[1:0], m[2:0], 2'b00});
				settle();
				raw = dec_base[b] << m;
				chk("decay_time_ms", (raw > 16'h5780) ? 16'h5780 : raw, decay_time_ms);
			end
		end
		chk("decay_sel_new", 16'h0001, {15'h0000, decay_sel_new});
		// The largest decay setting sits above every ceiling, so the output shows each one.
		for (int d = 0; d < 16; d++) begin
			@(posedge clk);
			codec_rate_divisor <= d[3:0];
			settle();
			chk("decay_time_ms", ceil_of(d[3:0]), decay_time_ms);
		end
		@(posedge clk);
		codec_rate_divisor <= 4'h2;
		legacy_decay_ms    <= 16'h7530;
		wr(right_agc_pkg::ADDR_DECAY, 8'h7C);
		settle();
		chk("decay_time_ms", right_agc_pkg::CEIL_4000, decay_time_ms);
		chk("decay_sel_new", 16'h0000, {15'h0000, decay_sel_new});
		// An unmapped write must not disturb either register.
		wr(8'h6B, 8'hA8);
		rd_chk(8'h6B, 8'h00);
		rd_chk(right_agc_pkg::ADDR_ATTACK, 8'h7C);
		rd_chk(right_agc_pkg::ADDR_DECAY, 8'h7C);
		// A read right behind a write sees the value that was just written.
		@(posedge clk);
		reg_wr    <= 1'b1;
		reg_addr  <= right_agc_pkg::ADDR_DECAY;
		reg_wdata <= 8'hE8;
		@(posedge clk);
		reg_wr <= 1'b0;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		chk("reg_rdata", 16'h00E8, {8'h00, reg_rdata});
		// A second reset in mid-run clears both registers again.
		wr(right_agc_pkg::ADDR_ATTACK, 8'hA4);
		@(posedge clk);
		rst_n <= 1'b0;
		@(posedge clk);
		rst_n <= 1'b1;
		rd_chk(right_agc_pkg::ADDR_ATTACK, 8'h00);
		rd_chk(right_agc_pkg::ADDR_DECAY, 8'h00);
		stop_test();
	end
endmodule
